// ==== src/flr_fault_latch_regs.sv ====
// Purpose: Latched diagnostic status for input two, output one and output two
// Assumes: Fault inputs arrive from analog monitors outside the clock domain
// Notes: Byte register port; reads are single-cycle strobes
//
// Overview of operation
// - Bit 7: input two open inputs
// - Bit 6: input two legs shorted together
// - Bits 5/4: positive/negative leg to ground
// - Bits 3/2: legs shorted to bias rail
// - Bits 1/0: legs shorted to battery rail
// - Output one short: bits 7/6
// - Output one virtual ground: bits 5/4
// - Output two short: bits 7/6
// - Output two virtual ground: bits 5/4
// - Output one bits 3/2: ADC overload masks
// - Output two bit 0 regulator, bit 1 mask
// - Fault bits clear without software writes
// - All three registers reset to zero
`include "flr_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module flr_fault_latch_regs (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire flr_pkg::flr_byte_t regWdata,
   input wire flr_pkg::flr_byte_t inputTwoFaults,
   input wire logic [3:0] outputOneFaults,
   input wire logic [3:0] outputTwoFaults,
   input wire logic regulatorShort,
   output logic [7:0] regRdata,
   output logic adcOneOverloadMask,
   output logic adcTwoOverloadMask,
   output logic regulatorShortMask,
   output logic regulatorSummary,
   output logic faultSummary
);
   import flr_pkg::*;
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [16:0] sync1;
      logic [16:0] sync2;
      logic [16:0] sync3;
      logic [16:0] stable;
      logic [1:0] adcMasks;
      logic regMask;
      flr_byte_t rdata;
      logic regSum;
      logic anySum;
   } flr_state_t;
   flr_state_t state_reg;
   flr_state_t state_next;
   logic [16:0] rawFaults;
   logic [16:0] clearVec;
   logic [16:0] flags;
   logic rdIn2;
   logic rdOut1;
   logic rdOut2;
   assign rawFaults = {regulatorShort, outputTwoFaults, outputOneFaults, inputTwoFaults};
   assign rdIn2 = regRead && (regAddr == `FLR_INPUT_TWO_OFFSET);
   assign rdOut1 = regRead && (regAddr == `FLR_OUTPUT_ONE_OFFSET);
   assign rdOut2 = regRead && (regAddr == `FLR_OUTPUT_TWO_OFFSET);
   assign clearVec = {rdOut2, {4{rdOut2}}, {4{rdOut1}}, {8{rdIn2}}};
   // ----------------------------------------
   // Sticky flags
   // ----------------------------------------
   // Read clears flags
   genvar gi;
   generate
      for (gi = 0; gi < 17; gi = gi + 1) begin : gFlag
         flr_sticky_bit uBit (
            .clk(clk),
            .nrst(nrst),
            .fault(state_reg.stable[gi]),
            .readClear(clearVec[gi]),
            .flag(flags[gi])
         );
      end
   endgenerate
   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.sync1 = rawFaults;
      state_next.sync2 = state_reg.sync1;
      state_next.sync3 = state_reg.sync2;
      // Pins count only once two stages agree, filtering single-cycle glitches
      for (int i = 0; i < 17; i++) begin
         if (state_reg.sync2[i] == state_reg.sync3[i]) begin
            state_next.stable[i] = state_reg.sync3[i];
         end
      end
      if (regWrite && regAddr == `FLR_OUTPUT_ONE_OFFSET) begin
         state_next.adcMasks = {regWdata[`FLR_ADC_ONE_MASK_BIT], regWdata[`FLR_ADC_TWO_MASK_BIT]};
      end
      if (regWrite && regAddr == `FLR_OUTPUT_TWO_OFFSET) begin
         state_next.regMask = regWdata[`FLR_REG_MASK_BIT];
      end
      if (rdIn2) begin
         state_next.rdata = flags[7:0];
      end else if (rdOut1) begin
         state_next.rdata = {flags[11:8], state_reg.adcMasks, 2'b00};
      end else if (rdOut2) begin
         state_next.rdata = {flags[15:12], 2'b00, state_reg.regMask, flags[16]};
      end else if (regRead) begin
         state_next.rdata = `FLR_RESET_VALUE;
      end
      state_next.regSum = flags[16] && !state_reg.regMask;
      state_next.anySum = (|flags[15:0]) || (flags[16] && !state_reg.regMask);
   end
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Reset to zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   assign regRdata = state_reg.rdata;
   assign adcOneOverloadMask = state_reg.adcMasks[1];
   assign adcTwoOverloadMask = state_reg.adcMasks[0];
   assign regulatorShortMask = state_reg.regMask;
   assign regulatorSummary = state_reg.regSum;
   assign faultSummary = state_reg.anySum;
endmodule
`default_nettype wire

// ==== src/flr_cfg.svh ====
// Purpose: Register offsets, field positions and reset values for the fault latch bank
// Assumes: 8-bit registers on an 8-bit register address
// Notes: Included by the fault latch register module
`ifndef FLR_CFG_SVH
`define FLR_CFG_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define FLR_INPUT_TWO_OFFSET 8'h37
`define FLR_OUTPUT_ONE_OFFSET 8'h38
`define FLR_OUTPUT_TWO_OFFSET 8'h39
// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define FLR_RESET_VALUE 8'h00
`define FLR_ADC_ONE_MASK_BIT 3
`define FLR_ADC_TWO_MASK_BIT 2
`define FLR_REG_MASK_BIT 1
`define FLR_REG_FLAG_BIT 0
`define FLR_OUTPUT_ONE_RW 8'h0c
`define FLR_OUTPUT_TWO_RW 8'h02
`endif

// ==== src/flr_pkg.sv ====
// Purpose: Types shared by the fault latch bank
// Assumes: Constants come from flr_cfg.svh
// Notes: One byte per register
package flr_pkg;
   typedef logic [7:0] flr_byte_t;
   typedef logic [15:0] flr_faults_t;
endpackage

// ==== src/flr_sticky_bit.sv ====
// Purpose: One sticky fault flag cleared by a host read
// Assumes: Fault input already synchronised by the caller
// Notes: A fault present in the read cycle keeps the flag set
`timescale 1ns/1ns
`default_nettype none
module flr_sticky_bit (
   input wire logic clk,
   input wire logic nrst,
   input wire logic fault,
   input wire logic readClear,
   output logic flag
);
   import flr_pkg::*;
   typedef struct packed {
      logic flag;
   } flr_bit_state_t;
   flr_bit_state_t state_reg;
   flr_bit_state_t state_next;
   always_comb begin
      state_next = state_reg;
      if (readClear) begin
         state_next.flag = 1'b0;
      end
      // Set wins over the read clear so no event is lost
      if (fault) begin
         state_next.flag = 1'b1;
      end
   end
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end
   assign flag = state_reg.flag;
endmodule
`default_nettype wire

// ==== tb/flr_fault_latch_regs_asserts.sv ====
// Purpose: Port checks for the fault latch bank
// Assumes: Sees the top module ports only
// Notes: Summary checks stay loose on latency
`timescale 1ns/1ns
`default_nettype none
module flr_chk (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire flr_pkg::flr_byte_t regWdata,
   input wire flr_pkg::flr_byte_t inputTwoFaults,
   input wire logic [7:0] regRdata,
   input wire logic adcOneOverloadMask,
   input wire logic adcTwoOverloadMask,
   input wire logic regulatorShortMask,
   input wire logic regulatorSummary,
   input wire logic faultSummary
);
   import flr_pkg::*;
   wire w8 = regWrite && regAddr == 8'h38;
   wire w9 = regWrite && regAddr == 8'h39;
   wire r8 = regRead && regAddr == 8'h38;
   wire r9 = regRead && regAddr == 8'h39;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_mask_one: assert property (w8 |=> adcOneOverloadMask == $past(regWdata[3]))
      else $error("adc one mask wrong");
   a_mask_two: assert property (w8 |=> adcTwoOverloadMask == $past(regWdata[2]))
      else $error("adc two mask wrong");
   a_reg_mask: assert property (w9 |=> regulatorShortMask == $past(regWdata[1]))
      else $error("regulator mask wrong");
   a_mask_rd: assert property (r8 |=> regRdata[3:2] == $past({adcOneOverloadMask, adcTwoOverloadMask}))
      else $error("mask readback wrong");
   a_rsv_one: assert property (r8 |=> regRdata[1:0] == 2'h0)
      else $error("reserved bits one set");
   a_rsv_two: assert property (r9 |=> regRdata[3:2] == 2'h0)
      else $error("reserved bits two set");
   a_reg_sum: assert property ($past(regulatorShortMask) && regulatorShortMask |-> !regulatorSummary)
      else $error("masked fault in summary");
   a_fault_sum: assert property ((inputTwoFaults != 8'h00) [*8] |-> faultSummary)
      else $error("held fault not latched");
endmodule
bind flr_fault_latch_regs flr_chk i_chk (.clk, .nrst, .regAddr, .regWrite, .regRead, .regWdata,
   .inputTwoFaults, .regRdata, .adcOneOverloadMask, .adcTwoOverloadMask, .regulatorShortMask,
   .regulatorSummary, .faultSummary);
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Register level test of the fault latch bank
// Assumes: Fault levels driven straight in
// Notes: Each fault held 8 cycles, dropped, then read twice
`timescale 1ns/1ns
`default_nettype none
`define CK(n, e, s) begin checked++; if ((s) !== (e)) begin err_count++; $display("Error %s exp %h got %h", n, e, s); end end
module testbench;
   logic clk = 0;
   logic nrst = 0;
   logic regWrite = 0;
   logic regRead = 0;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWdata = 8'h00;
   logic [16:0] flt = 17'h0;
   logic [7:0] regRdata;
   logic [7:0] a;
   logic [7:0] m;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   int b;
   always #5 clk = ~clk;
   flr_fault_latch_regs i_dut (.clk, .nrst, .regAddr, .regWrite, .regRead, .regWdata,
      .inputTwoFaults(flt[16:9]), .outputOneFaults(flt[8:5]), .outputTwoFaults(flt[4:1]),
      .regulatorShort(flt[0]), .regRdata, .adcOneOverloadMask(), .adcTwoOverloadMask(),
      .regulatorShortMask(), .regulatorSummary(), .faultSummary());
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      regAddr <= ad;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] e);
      @(posedge clk);
      regAddr <= ad;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      @(posedge clk);
      #1 `CK("regRdata", e, regRdata)
   endtask
   task finish_test;
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Ceiling well above the roughly 430 cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         finish_test;
      end
   end
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      rd(8'h37, 8'h00);
      rd(8'h38, 8'h00);
      rd(8'h39, 8'h00);
      wr(8'h37, 8'hff);
      wr(8'h38, 8'hfc);
      wr(8'h39, 8'hf3);
      rd(8'h37, 8'h00);
      rd(8'h38, 8'h0c);
      rd(8'h39, 8'h02);
      $display("test registers done");
      // Masks stay set, so the regulator flag is seen latched while masked
      for (int j = 0; j < 17; j++) begin
         @(posedge clk);
         flt <= 17'(1 << j);
         repeat (8) @(posedge clk);
         flt <= 17'h0;
         repeat (8) @(posedge clk);
         a = j > 8 ? 8'h37 : j > 4 ? 8'h38 : 8'h39;
         m = j > 8 ? 8'h00 : j > 4 ? 8'h0c : 8'h02;
         b = j > 8 ? j - 9 : j > 4 ? j - 1 : j > 0 ? j + 3 : 0;
         rd(a, m | 8'(1 << b));
         rd(a, m);
      end
      $display("test faults done");
      finish_test;
   end
endmodule
`default_nettype wire
